// ### wqw_watchdog.sv
// Windowed simple / question-answer watchdog with its register set.
// Assumes the serial register interface delivers one-cycle read and write
// strobes synchronous to clk; read data appears one cycle after the strobe.
//
// Operation
// - Status shows live reset pin level
// - Status shows open window active live
// - Fault bit after configured failures, mismatch excluded
// - Wrong key latches mismatch, read clears
// - Simple-mode or correct key write in closed window latches early
// - No key write whole window latches expired
// - Mode bit 0 answers, 1 simple
// - Tick period (divider+1) times base, scale x64
// - Closed phase ticks (field+1) times 8
// - Open phase ticks (field+1) times 8
// - Enable runs; failures reach count, report
// - First window lengths times (extension+1)
// - Key register reads current key
// - Simple mode: any key write in open refreshes
// - Answer mode: wrong key ignored, mismatch
// - Correct key in open refreshes, updates key
// - Correct key in closed ignored, early
// - Key sequence from 8-bit LFSR polynomial
// - Lock bit makes clock, window and fail/enable configuration read-only
// - Errors drive reset only when mapped
`include "wqw_consts.svh"
module wqw_watchdog
    import wqw_pkg::*;
#(
    parameter int BASE_TICK_CYC = `WQW_BASE_TICK_CYC
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Register access
    input  wire wqw_pkg::wqw_reg_req_t reg_req,
    output logic [7:0]             reg_rdata,
    // Reset pin
    input  wire logic              reset_pin_level,
    output logic                   system_reset_output_n,
    // Live window status
    output logic                   update_window_active
);
    import wqw_pkg::*;
    // Configuration registers
    logic       simple_mode_select;
    logic       tick_base_select;
    logic [5:0] tick_divider;
    logic [3:0] closed_phase_length;
    logic [3:0] open_phase_length;
    logic       failure_threshold;
    logic       watchdog_enable_bit;
    logic [2:0] first_window_extension;
    logic       config_write_protect;
    logic       fault_to_reset_map;
    logic [7:0] service_key;

    // Status and internal state
    logic        key_mismatch_flag;
    logic        early_update_flag;
    logic        window_expired_flag;
    logic        watchdog_fault;
    logic [1:0]  fail_count;
    logic        first_window;
    wqw_phase_t  phase;
    logic [31:0] base_cnt;
    logic [5:0]  scale_cnt;
    logic [5:0]  div_cnt;
    logic [10:0] win_cnt;

    // Decoded strobes and events
    logic       key_write;
    logic       cfg_write_ok;
    logic       status_read;
    logic       base_pulse;
    logic       scaled_pulse;
    logic       wd_tick;
    logic [7:0] next_key;
    logic       key_correct;
    logic       refresh;
    logic       early_event;
    logic       mismatch_event;
    logic       expire_event;
    logic       phase_end;
    logic [10:0] phase_ticks;
    logic        next_fault;

    // Access decode
    assign key_write    = reg_req.wr && reg_req.addr == `WQW_ADDR_KEY;
    assign status_read  = reg_req.rd && reg_req.addr == `WQW_ADDR_STATUS;
    assign cfg_write_ok = reg_req.wr && !config_write_protect;

    // Next answer of the sequence, taps 8,6,5,4
    assign next_key = {service_key[6:0],
                       service_key[7] ^ service_key[5] ^ service_key[4] ^ service_key[3]};
    assign key_correct = reg_req.wdata == next_key;

    // Key write classification per mode and phase
    always_comb begin
        refresh        = 1'b0;
        early_event    = 1'b0;
        mismatch_event = 1'b0;
        if (key_write && phase != WQW_IDLE) begin
            if (simple_mode_select) begin
                refresh     = (phase == WQW_OPEN);
                early_event = (phase == WQW_CLOSED);
            end else if (!key_correct) begin
                mismatch_event = 1'b1;
            end else begin
                refresh     = (phase == WQW_OPEN);
                early_event = (phase == WQW_CLOSED);
            end
        end
    end

    // Base tick of 128 us; restarts on enable and on refresh so each window is whole
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_cnt <= 32'h0000_0000;
        end else if (phase == WQW_IDLE || refresh || base_pulse) begin
            base_cnt <= 32'h0000_0000;
        end else begin
            base_cnt <= base_cnt + 32'h0000_0001;
        end
    end
    assign base_pulse = phase != WQW_IDLE && base_cnt == 32'(BASE_TICK_CYC - 1);

    // Optional x64 prescale of the base tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scale_cnt <= 6'h00;
        end else if (phase == WQW_IDLE || refresh) begin
            scale_cnt <= 6'h00;
        end else if (base_pulse) begin
            scale_cnt <= scale_cnt + 6'h01;
        end
    end
    assign scaled_pulse = base_pulse &&
        (!tick_base_select || scale_cnt == 6'(`WQW_SCALE_FACTOR - 1));

    // Watchdog clock divider: one tick per (divider+1) scaled pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= 6'h00;
        end else if (phase == WQW_IDLE || refresh || wd_tick) begin
            div_cnt <= 6'h00;
        end else if (scaled_pulse) begin
            div_cnt <= div_cnt + 6'h01;
        end
    end
    assign wd_tick = scaled_pulse && div_cnt == tick_divider;

    // Phase length in watchdog ticks, stretched in the first window
    always_comb begin
        logic [10:0] base_len;
        base_len = 11'({closed_phase_length, 3'b000}) + 11'h008;
        if (phase == WQW_OPEN) begin
            base_len = 11'({open_phase_length, 3'b000}) + 11'h008;
        end
        phase_ticks = base_len;
        if (first_window) begin
            phase_ticks = 11'(base_len * ({8'h00, first_window_extension} + 11'h001));
        end
    end
    assign phase_end    = wd_tick && win_cnt == phase_ticks - 11'h001;
    assign expire_event = phase == WQW_OPEN && phase_end && !refresh;

    // Window sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase   <= WQW_IDLE;
            win_cnt <= 11'h000;
        end else if (!watchdog_enable_bit) begin
            phase   <= WQW_IDLE;
            win_cnt <= 11'h000;
        end else begin
            unique case (phase)
                WQW_IDLE: begin
                    phase   <= WQW_CLOSED;
                end
                WQW_CLOSED: begin
                    if (phase_end) begin
                        phase   <= WQW_OPEN;
                        win_cnt <= 11'h000;
                    end else if (wd_tick) begin
                        win_cnt <= win_cnt + 11'h001;
                    end
                end
                WQW_OPEN: begin
                    if (refresh || phase_end) begin
                        phase   <= WQW_CLOSED;
                        win_cnt <= 11'h000;
                    end else if (wd_tick) begin
                        win_cnt <= win_cnt + 11'h001;
                    end
                end
            endcase
        end
    end

    // First-window stretch lasts until the first window is over
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_window <= 1'b1;
        end else if (phase == WQW_OPEN && (refresh || phase_end)) begin
            first_window <= 1'b0;
        end
    end

    // Service key: advances only on a correct answer in the open window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            service_key <= `WQW_RST_KEY;
        end else if (refresh && !simple_mode_select) begin
            service_key <= next_key;
        end
    end

    // Configuration writes, ignored while locked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {simple_mode_select, tick_base_select, tick_divider} <= `WQW_RST_CLOCK_CFG;
            {closed_phase_length, open_phase_length}             <= `WQW_RST_WINDOW_CFG;
            failure_threshold      <= 1'(`WQW_RST_FAIL_EN_CFG >> 4);
            watchdog_enable_bit    <= 1'(`WQW_RST_FAIL_EN_CFG >> 3);
            first_window_extension <= 3'(`WQW_RST_FAIL_EN_CFG);
        end else if (cfg_write_ok) begin
            unique case (reg_req.addr)
                `WQW_ADDR_CLOCK_CFG: begin
                    {simple_mode_select, tick_base_select, tick_divider} <= reg_req.wdata;
                end
                `WQW_ADDR_WINDOW_CFG: begin
                    {closed_phase_length, open_phase_length} <= reg_req.wdata;
                end
                `WQW_ADDR_FAIL_EN_CFG: begin
                    failure_threshold      <= reg_req.wdata[4];
                    watchdog_enable_bit    <= reg_req.wdata[3];
                    first_window_extension <= reg_req.wdata[2:0];
                end
                default: ;
            endcase
        end
    end

    // Lock and reset mapping bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            config_write_protect <= 1'b0;
            fault_to_reset_map   <= `WQW_RST_RESET_MAP;
        end else if (reg_req.wr && reg_req.addr == `WQW_ADDR_LOCK) begin
            config_write_protect <= reg_req.wdata[0];
        end else if (reg_req.wr && reg_req.addr == `WQW_ADDR_RESET_MAP) begin
            fault_to_reset_map <= reg_req.wdata[0];
        end
    end

    // Read-clear violation flags; a new event wins over the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            key_mismatch_flag   <= 1'b0;
            early_update_flag   <= 1'b0;
            window_expired_flag <= 1'b0;
        end else begin
            key_mismatch_flag   <= mismatch_event | (key_mismatch_flag & !status_read);
            early_update_flag   <= early_event | (early_update_flag & !status_read);
            window_expired_flag <= expire_event | (window_expired_flag & !status_read);
        end
    end

    // Failure counting: early updates and expiries only
    assign next_fault = (fail_count + 2'(early_event | expire_event)) >=
                        (failure_threshold ? 2'd2 : 2'd1);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fail_count     <= 2'd0;
            watchdog_fault <= 1'b0;
        end else if (early_event || expire_event) begin
            if (fail_count != 2'd2) begin
                fail_count <= fail_count + 2'd1;
            end
            watchdog_fault <= watchdog_fault | next_fault;
        end
    end

    // Reset output: low while a mapped watchdog error stands
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            system_reset_output_n <= 1'b1;
        end else begin
            system_reset_output_n <= !(fault_to_reset_map &&
                (watchdog_fault || key_mismatch_flag));
        end
    end

    // Live open window indication
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            update_window_active <= 1'b0;
        end else begin
            update_window_active <= (phase == WQW_OPEN) && !(refresh || phase_end);
        end
    end

    // Read data, registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `WQW_ADDR_STATUS: begin
                    reg_rdata <= {2'b00, reset_pin_level, phase == WQW_OPEN, watchdog_fault,
                                  key_mismatch_flag, early_update_flag, window_expired_flag};
                end
                `WQW_ADDR_CLOCK_CFG: begin
                    reg_rdata <= {simple_mode_select, tick_base_select, tick_divider};
                end
                `WQW_ADDR_WINDOW_CFG: begin
                    reg_rdata <= {closed_phase_length, open_phase_length};
                end
                `WQW_ADDR_FAIL_EN_CFG: begin
                    reg_rdata <= {3'b000, failure_threshold, watchdog_enable_bit,
                                  first_window_extension};
                end
                `WQW_ADDR_KEY:       reg_rdata <= service_key;
                `WQW_ADDR_LOCK:      reg_rdata <= {7'h00, config_write_protect};
                `WQW_ADDR_RESET_MAP: reg_rdata <= {7'h00, fault_to_reset_map};
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_mismatch_sets_flag: assert property (mismatch_event |=> key_mismatch_flag)
        else $error("mismatch flag not set");
    a_early_sets_flag: assert property (early_event |=> early_update_flag)
        else $error("early flag not set");
    a_expiry_sets_flag: assert property (expire_event |=> window_expired_flag)
        else $error("expired flag not set");
    a_key_stays_wrong: assert property (mismatch_event |=> $stable(service_key))
        else $error("key changed on wrong answer");
    a_key_advances_ok: assert property (refresh && !simple_mode_select
        |=> service_key == $past(next_key))
        else $error("key not advanced");
    a_early_no_update: assert property (early_event |=> $stable(service_key))
        else $error("key changed on early write");
    a_closed_after_open: assert property (phase == WQW_OPEN && phase_end && watchdog_enable_bit
        |=> phase == WQW_CLOSED && win_cnt == 11'h000)
        else $error("no restart after expiry");
    a_reset_unmapped: assert property (!fault_to_reset_map ##1 !fault_to_reset_map
        |-> system_reset_output_n)
        else $error("reset driven while unmapped");
    a_fault_one_fail: assert property (!failure_threshold && watchdog_enable_bit && expire_event
        |=> watchdog_fault ##1 !system_reset_output_n || !fault_to_reset_map)
        else $error("fault not raised");
    a_locked_config: assert property (config_write_protect && reg_req.wr
        |=> $stable(tick_divider) && $stable(watchdog_enable_bit))
        else $error("locked config changed");
    a_open_window_bit: assert property ($rose(phase == WQW_OPEN) && !refresh
        |=> update_window_active)
        else $error("open window not shown");
    c_refresh: cover property (refresh && !simple_mode_select);
    c_expiry: cover property (expire_event);
    c_early: cover property (early_event);
    c_reset_out: cover property ($fell(system_reset_output_n));
endmodule

// ### wqw_consts.svh
// Offsets, field positions, reset values and timing figures of the watchdog.
// Included by the package and the watchdog module; definitions only.
`ifndef WQW_CONSTS_SVH
`define WQW_CONSTS_SVH

// Register offsets
`define WQW_ADDR_RESET_MAP     8'h08
`define WQW_ADDR_STATUS        8'h0E
`define WQW_ADDR_CLOCK_CFG     8'h13
`define WQW_ADDR_WINDOW_CFG    8'h14
`define WQW_ADDR_FAIL_EN_CFG   8'h15
`define WQW_ADDR_KEY           8'h16
`define WQW_ADDR_LOCK          8'h17

// Status field positions
`define WQW_ST_PIN_LEVEL       5
`define WQW_ST_OPEN            4
`define WQW_ST_FAULT           3
`define WQW_ST_MISMATCH        2
`define WQW_ST_EARLY           1
`define WQW_ST_EXPIRED         0

// Reset values
`define WQW_RST_CLOCK_CFG      8'h00
`define WQW_RST_WINDOW_CFG     8'h00
`define WQW_RST_FAIL_EN_CFG    8'h00
`define WQW_RST_KEY            8'h01
`define WQW_RST_RESET_MAP      1'b1

// Timing: base tick in ns, clock period in ns, scale and window factors
`define WQW_BASE_TICK_NS       128000
`define WQW_CLK_PERIOD_NS      10
`define WQW_BASE_TICK_CYC      (`WQW_BASE_TICK_NS / `WQW_CLK_PERIOD_NS)
`define WQW_SCALE_FACTOR       64
`define WQW_WINDOW_FACTOR      8

`endif

// ### wqw_pkg.sv
// Types shared by the watchdog design.
// Assumes wqw_consts.svh sits in the include path.
package wqw_pkg;
    `include "wqw_consts.svh"

    // Window phase of the watchdog
    typedef enum logic [1:0] {
        WQW_IDLE,
        WQW_CLOSED,
        WQW_OPEN
    } wqw_phase_t;

    // Register access request from the serial register interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wqw_reg_req_t;
endpackage

// ### wqw_mcu_model.sv
// Processor model that services the watchdog over its register strobes.
// Assumes requests are taken at the rising clk edge and read data lands one cycle later.
`include "wqw_consts.svh"
module wqw_mcu_model
    import wqw_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Register access
    output wqw_pkg::wqw_reg_req_t reg_req,
    input  wire logic [7:0]       reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles with no strobe
    initial begin
        reg_req = '0;
    end

    // One access; a released bus drops both strobes and shows the inverse of the last address and data
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk);
        reg_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
        q = reg_rdata;
    endtask

    // Answer the question: read the key, write its successor
    task automatic service();
        logic [7:0] k;
        logic [7:0] unused_q;
        access(1'b0, `WQW_ADDR_KEY, 8'h00, k);
        access(1'b1, `WQW_ADDR_KEY, {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]}, unused_q);
    endtask
endmodule

// ### tb_windowed_qa_watchdog.sv
// Self-checking bench for the windowed watchdog, driven through the processor model.
// Assumes a pulled-up reset pin whose sensed level follows the watchdog reset output.
`include "wqw_consts.svh"
module tb_windowed_qa_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    import wqw_pkg::*;

    logic                  clk;
    logic                  resetn;
    wqw_pkg::wqw_reg_req_t reg_req;
    logic [7:0]            reg_rdata;
    logic                  reset_pin_level;
    logic                  system_reset_output_n;
    logic                  update_window_active;
    int                    n_mismatch = 0;
    int                    comparisons = 0;
    int                    cyc;

    // Pin with pull-up: low only while the watchdog pulls it
    assign reset_pin_level = system_reset_output_n;

    wqw_watchdog #(.BASE_TICK_CYC(4)) wqw_watchdog_inst (
        .clk                   (clk),
        .resetn                (resetn),
        .reg_req               (reg_req),
        .reg_rdata             (reg_rdata),
        .reset_pin_level       (reset_pin_level),
        .system_reset_output_n (system_reset_output_n),
        .update_window_active  (update_window_active)
    );

    wqw_mcu_model wqw_mcu_model_inst (
        .clk       (clk),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wqw_mcu_model_inst.access(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] q;
        wqw_mcu_model_inst.access(1'b0, a, 8'h00, q);
        check(name, exp, q);
    endtask

    // Cycles until the open window flag reaches the wanted level, bounded
    task automatic wait_active(input logic lvl, output int c);
        c = 0;
        while (update_window_active !== lvl && c < 3000) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    task automatic check_range(input string name, input int lo, input int hi, input int c);
        comparisons++;
        if (c < lo || c > hi) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d to %0d seen %0d", name, lo, hi, c);
        end
    endtask

    // Reset held for four cycles
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end

    // Test sequence
    initial begin
        resetn = 1'b0;
        do_reset();
        // Reset values, unmapped place, disabled key write
        rd(`WQW_ADDR_CLOCK_CFG, 8'h00, "clock_cfg");
        rd(`WQW_ADDR_WINDOW_CFG, 8'h00, "window_cfg");
        rd(`WQW_ADDR_FAIL_EN_CFG, 8'h00, "fail_en_cfg");
        rd(`WQW_ADDR_LOCK, 8'h00, "lock");
        rd(`WQW_ADDR_STATUS, 8'h20, "status_idle");
        rd(8'h30, 8'h00, "unmapped");
        wr(`WQW_ADDR_KEY, 8'h02);
        rd(`WQW_ADDR_KEY, 8'h01, "key_disabled");
        // Answer mode, two failures needed
        wr(`WQW_ADDR_FAIL_EN_CFG, 8'h18);
        rd(`WQW_ADDR_FAIL_EN_CFG, 8'h18, "fail_en_rb");
        wr(`WQW_ADDR_KEY, 8'h02);
        rd(`WQW_ADDR_STATUS, 8'h22, "status_early");
        rd(`WQW_ADDR_STATUS, 8'h20, "status_cleared");
        rd(`WQW_ADDR_KEY, 8'h01, "key_early");
        wait_active(1'b1, cyc);
        wr(`WQW_ADDR_KEY, 8'h55);
        repeat (3) @(posedge clk);
        #1;
        check("reset_out_mismatch", 8'h00, {7'h00, system_reset_output_n});
        rd(`WQW_ADDR_STATUS, 8'h14, "status_mismatch");
        rd(`WQW_ADDR_STATUS, 8'h30, "status_mm_clear");
        rd(`WQW_ADDR_KEY, 8'h01, "key_mismatch");
        wqw_mcu_model_inst.service();
        rd(`WQW_ADDR_KEY, 8'h02, "key_refreshed");
        check("open_after_refresh", 8'h00, {7'h00, update_window_active});
        // Let a whole window pass unserviced: second failure
        wait_active(1'b1, cyc);
        wait_active(1'b0, cyc);
        check_range("open_len", 30, 34, cyc);
        repeat (3) @(posedge clk);
        rd(`WQW_ADDR_STATUS, 8'h09, "status_expired");
        check("reset_out_fault", 8'h00, {7'h00, system_reset_output_n});
        // Lock protection
        wr(`WQW_ADDR_LOCK, 8'h01);
        wr(`WQW_ADDR_WINDOW_CFG, 8'hff);
        rd(`WQW_ADDR_WINDOW_CFG, 8'h00, "window_locked");
        wr(`WQW_ADDR_LOCK, 8'h00);
        wr(`WQW_ADDR_WINDOW_CFG, 8'h5a);
        rd(`WQW_ADDR_WINDOW_CFG, 8'h5a, "window_unlocked");
        // Simple mode, divider 1 (tick 8 cycles), first window doubled
        do_reset();
        wr(`WQW_ADDR_CLOCK_CFG, 8'h81);
        wr(`WQW_ADDR_FAIL_EN_CFG, 8'h09);
        wait_active(1'b1, cyc);
        check_range("first_closed", 128, 133, cyc);
        rd(`WQW_ADDR_STATUS, 8'h30, "status_open");
        wr(`WQW_ADDR_KEY, 8'hab);
        wait_active(1'b1, cyc);
        check_range("closed_len", 62, 68, cyc);
        rd(`WQW_ADDR_KEY, 8'h01, "key_simple");
        rd(`WQW_ADDR_STATUS, 8'h30, "status_simple");
        wr(`WQW_ADDR_KEY, 8'h00);
        // Early write with mapping off, then on
        wr(`WQW_ADDR_RESET_MAP, 8'h00);
        wr(`WQW_ADDR_KEY, 8'h00);
        repeat (3) @(posedge clk);
        rd(`WQW_ADDR_STATUS, 8'h2a, "status_unmapped");
        wr(`WQW_ADDR_RESET_MAP, 8'h01);
        repeat (3) @(posedge clk);
        #1;
        check("reset_out_mapped", 8'h00, {7'h00, system_reset_output_n});
        rd(`WQW_ADDR_STATUS, 8'h08, "status_mapped");
        // Long base: scale x64 gives 256-cycle ticks, closed window of 8 ticks
        do_reset();
        wr(`WQW_ADDR_CLOCK_CFG, 8'hc0);
        wr(`WQW_ADDR_FAIL_EN_CFG, 8'h08);
        wait_active(1'b1, cyc);
        check_range("scaled_closed", 2048, 2053, cyc);
        end_of_test();
    end
endmodule
